/* File: src/pim_port_io.sv */
// Port configuration registers, pin drive, readback and match event logic
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`include "pim_defs.svh"
module pim_port_io (
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  // Special-function register bus
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic       sfr_rmw_i,
  input  wire logic       sfr_bit_i,
  input  wire logic [2:0] sfr_bit_sel_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // Interrupt enable and match outputs
  input  wire logic       match_interrupt_enable_i,
  output logic            match_irq_o,
  output logic            match_wake_o,
  // Crossbar signals
  input  wire logic [7:0] xbar_p2_sel_i,
  input  wire logic [7:0] xbar_p2_out_i,
  input  wire logic [7:0] xbar_p2_oe_i,
  input  wire logic [7:0] xbar_p3_sel_i,
  input  wire logic [7:0] xbar_p3_out_i,
  input  wire logic [7:0] xbar_p3_oe_i,
  input  wire logic [7:0] xbar_p4_sel_i,
  input  wire logic [7:0] xbar_p4_out_i,
  input  wire logic [7:0] xbar_p4_oe_i,
  output logic      [7:0] port1_skip_o,
  output logic      [7:0] port2_skip_o,
  output logic      [7:0] port3_skip_o,
  output logic      [7:0] port1_digital_o,
  output logic      [7:0] port2_digital_o,
  output logic      [7:0] port3_digital_o,
  output logic      [7:0] port1_push_pull_o,
  // Pins
  input  wire logic [7:0] port1_pin_i,
  input  wire logic [7:0] port2_pin_i,
  input  wire logic [7:0] port3_pin_i,
  input  wire logic [6:0] port4_pin_i,
  output logic      [7:0] port2_pin_o,
  output logic      [7:0] port2_pin_oe_o,
  output logic      [7:0] port3_pin_o,
  output logic      [7:0] port3_pin_oe_o,
  output logic      [6:0] port4_pin_o,
  output logic      [6:0] port4_pin_oe_o
);
  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [7:0] p1_s;
  logic [7:0] p2_s;
  logic [7:0] p3_s;
  logic [7:0] p4_s;

  pim_sync #(
    .WIDTH(8)
  ) u_sync1 (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    (port1_pin_i),
    .sync_o     (p1_s)
  );

  pim_sync #(
    .WIDTH(8)
  ) u_sync2 (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    (port2_pin_i),
    .sync_o     (p2_s)
  );

  pim_sync #(
    .WIDTH(8)
  ) u_sync3 (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    (port3_pin_i),
    .sync_o     (p3_s)
  );

  pim_sync #(
    .WIDTH(8)
  ) u_sync4 (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    ({1'b0, port4_pin_i}),
    .sync_o     (p4_s)
  );

  pim_pkg::pim_state_s r;
  pim_pkg::pim_state_s next_r;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Byte write or single-bit write into a latch
  function automatic pim_pkg::pim_byte_t upd(input pim_pkg::pim_byte_t old, input logic bitw,
                                             input logic [2:0] sel, input pim_pkg::pim_byte_t wd);
    pim_pkg::pim_byte_t v;
    v = old;
    if (bitw) begin
      v[sel] = wd[0];
    end else begin
      v = wd;
    end
    return v;
  endfunction

  // Masked compare; bits clear in the mask can never mismatch
  function automatic logic mismatch(input pim_pkg::pim_byte_t pins, input pim_pkg::pim_byte_t mval,
                                    input pim_pkg::pim_byte_t mmask);
    return (pins & mmask) != (mval & mmask);
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  logic [7:0] p2_drv_out;
  logic [7:0] p2_drv_oe;
  logic [7:0] p3_drv_out;
  logic [7:0] p3_drv_oe;
  logic [7:0] p4_drv_out;
  logic [7:0] p4_drv_oe;
  logic       p1_mismatch;
  logic       p2_mismatch;
  logic       any_match;

  pim_pin_drive u_drv2 (
    .latch_i     (r.p2_latch),
    .push_pull_i (r.p2_omode),
    .digital_i   (r.p2_imode),
    .xbar_sel_i  (xbar_p2_sel_i),
    .xbar_out_i  (xbar_p2_out_i),
    .xbar_oe_i   (xbar_p2_oe_i),
    .pin_out_o   (p2_drv_out),
    .pin_oe_o    (p2_drv_oe)
  );
  pim_pin_drive u_drv3 (
    .latch_i     (r.p3_latch),
    .push_pull_i (r.p3_omode),
    .digital_i   (r.p3_imode),
    .xbar_sel_i  (xbar_p3_sel_i),
    .xbar_out_i  (xbar_p3_out_i),
    .xbar_oe_i   (xbar_p3_oe_i),
    .pin_out_o   (p3_drv_out),
    .pin_oe_o    (p3_drv_oe)
  );
  // Port 4 has no analog mode, so every pin counts as digital
  pim_pin_drive u_drv4 (
    .latch_i     (r.p4_latch),
    .push_pull_i (r.p4_omode),
    .digital_i   (`PIM_PORT4_MASK),
    .xbar_sel_i  (xbar_p4_sel_i),
    .xbar_out_i  (xbar_p4_out_i),
    .xbar_oe_i   (xbar_p4_oe_i),
    .pin_out_o   (p4_drv_out),
    .pin_oe_o    (p4_drv_oe)
  );

  always_comb begin
    next_r = r;

    // -------------------------------------------------------------------------
    // Match compare
    // -------------------------------------------------------------------------
    // Port 1 pins are driven elsewhere; analog pins compare as zero
    p1_mismatch = mismatch(p1_s & r.p1_imode, r.p1_mval, r.p1_mmask);
    p2_mismatch = mismatch(p2_s & r.p2_imode, r.p2_mval, r.p2_mmask);
    any_match   = p1_mismatch | p2_mismatch;

    // -------------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------------
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        // Latches sit on every page; ports 2 and 3 take bit writes
        `PIM_ADDR_PORT2_LATCH:       next_r.p2_latch = upd(r.p2_latch, sfr_bit_i, sfr_bit_sel_i, sfr_wdata_i);
        `PIM_ADDR_PORT3_LATCH:       next_r.p3_latch = upd(r.p3_latch, sfr_bit_i, sfr_bit_sel_i, sfr_wdata_i);
        `PIM_ADDR_PORT4_LATCH:       next_r.p4_latch = sfr_wdata_i & `PIM_PORT4_MASK;
        `PIM_ADDR_PORT1_OUTPUT_MODE: next_r.p1_omode = sfr_wdata_i;
        `PIM_ADDR_PORT2_OUTPUT_MODE: next_r.p2_omode = sfr_wdata_i;
        `PIM_ADDR_PORT3_OUTPUT_MODE: next_r.p3_omode = sfr_wdata_i;
        `PIM_ADDR_PORT4_OUTPUT_MODE: next_r.p4_omode = sfr_wdata_i & `PIM_PORT4_MASK;
        `PIM_ADDR_PORT1_INPUT_MODE:  next_r.p1_imode = sfr_wdata_i;
        `PIM_ADDR_PORT2_INPUT_MODE:  next_r.p2_imode = sfr_wdata_i;
        `PIM_ADDR_PORT3_INPUT_MODE:  next_r.p3_imode = sfr_wdata_i;
        `PIM_ADDR_PORT1_SKIP:        next_r.p1_skip  = sfr_wdata_i;
        `PIM_ADDR_PORT2_SKIP:        next_r.p2_skip  = sfr_wdata_i;
        `PIM_ADDR_PORT3_SKIP:        next_r.p3_skip  = sfr_wdata_i;
        `PIM_ADDR_PORT1_MATCH_VALUE: next_r.p1_mval  = sfr_wdata_i;
        `PIM_ADDR_PORT1_MATCH_MASK:  next_r.p1_mmask = sfr_wdata_i;
        `PIM_ADDR_PORT2_MATCH_VALUE: next_r.p2_mval  = sfr_wdata_i;
        `PIM_ADDR_PORT2_MATCH_MASK:  next_r.p2_mmask = sfr_wdata_i;
        default: ;
      endcase
    end

    // -------------------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------------------
    next_r.rd_data = `PIM_RST_ZERO;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        // Plain reads see the pin; read-modify-write sees the latch
        `PIM_ADDR_PORT2_LATCH:       next_r.rd_data = sfr_rmw_i ? r.p2_latch : (p2_s & r.p2_imode);
        `PIM_ADDR_PORT3_LATCH:       next_r.rd_data = sfr_rmw_i ? r.p3_latch : (p3_s & r.p3_imode);
        `PIM_ADDR_PORT4_LATCH:       next_r.rd_data = sfr_rmw_i ? r.p4_latch : (p4_s & `PIM_PORT4_MASK);
        `PIM_ADDR_PORT1_OUTPUT_MODE: next_r.rd_data = r.p1_omode;
        `PIM_ADDR_PORT2_OUTPUT_MODE: next_r.rd_data = r.p2_omode;
        `PIM_ADDR_PORT3_OUTPUT_MODE: next_r.rd_data = r.p3_omode;
        `PIM_ADDR_PORT4_OUTPUT_MODE: next_r.rd_data = r.p4_omode;
        `PIM_ADDR_PORT1_INPUT_MODE:  next_r.rd_data = r.p1_imode;
        `PIM_ADDR_PORT2_INPUT_MODE:  next_r.rd_data = r.p2_imode;
        `PIM_ADDR_PORT3_INPUT_MODE:  next_r.rd_data = r.p3_imode;
        `PIM_ADDR_PORT1_SKIP:        next_r.rd_data = r.p1_skip;
        `PIM_ADDR_PORT2_SKIP:        next_r.rd_data = r.p2_skip;
        `PIM_ADDR_PORT3_SKIP:        next_r.rd_data = r.p3_skip;
        `PIM_ADDR_PORT1_MATCH_VALUE: next_r.rd_data = r.p1_mval;
        `PIM_ADDR_PORT1_MATCH_MASK:  next_r.rd_data = r.p1_mmask;
        `PIM_ADDR_PORT2_MATCH_VALUE: next_r.rd_data = r.p2_mval;
        `PIM_ADDR_PORT2_MATCH_MASK:  next_r.rd_data = r.p2_mmask;
        default:                     next_r.rd_data = `PIM_RST_ZERO;
      endcase
    end

    // -------------------------------------------------------------------------
    // Pin drive and crossbar outputs
    // -------------------------------------------------------------------------
    // Registered pin drive; one cycle behind the latch and crossbar
    next_r.p2_out = p2_drv_out;
    next_r.p2_oe  = p2_drv_oe;
    next_r.p3_out = p3_drv_out;
    next_r.p3_oe  = p3_drv_oe;
    next_r.p4_out = p4_drv_out & `PIM_PORT4_MASK;
    next_r.p4_oe  = p4_drv_oe & `PIM_PORT4_MASK;

    next_r.p1_digital  = r.p1_imode;
    next_r.p2_digital  = r.p2_imode;
    next_r.p3_digital  = r.p3_imode;
    next_r.p1_pushpull = r.p1_omode & r.p1_imode;
    next_r.p1_skip_o   = r.p1_skip;
    next_r.p2_skip_o   = r.p2_skip;
    next_r.p3_skip_o   = r.p3_skip;

    // -------------------------------------------------------------------------
    // Match event
    // -------------------------------------------------------------------------
    // Wake is unconditional; the interrupt request waits on its enable
    next_r.match_wake = any_match;
    next_r.match_irq  = any_match & match_interrupt_enable_i;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r          <= '0;
      r.p2_latch <= `PIM_RST_ONES;
      r.p3_latch <= `PIM_RST_ONES;
      r.p4_latch <= `PIM_RST_PORT4_LATCH;
      r.p1_imode <= `PIM_RST_ONES;
      r.p2_imode <= `PIM_RST_ONES;
      r.p3_imode <= `PIM_RST_ONES;
      r.p1_mval  <= `PIM_RST_ONES;
      r.p2_mval  <= `PIM_RST_ONES;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign sfr_rdata_o       = r.rd_data;
  assign match_irq_o       = r.match_irq;
  assign match_wake_o      = r.match_wake;
  assign port1_skip_o      = r.p1_skip_o;
  assign port2_skip_o      = r.p2_skip_o;
  assign port3_skip_o      = r.p3_skip_o;
  assign port1_digital_o   = r.p1_digital;
  assign port2_digital_o   = r.p2_digital;
  assign port3_digital_o   = r.p3_digital;
  assign port1_push_pull_o = r.p1_pushpull;
  assign port2_pin_o       = r.p2_out;
  assign port2_pin_oe_o    = r.p2_oe;
  assign port3_pin_o       = r.p3_out;
  assign port3_pin_oe_o    = r.p3_oe;
  assign port4_pin_o       = r.p4_out[6:0];
  assign port4_pin_oe_o    = r.p4_oe[6:0];
endmodule // pim_port_io

/* File: src/pim_defs.svh */
// Register addresses, reset values and widths for the port configuration and match block
`ifndef PIM_DEFS_SVH
`define PIM_DEFS_SVH

`define PIM_ADDR_PORT2_LATCH        8'hA0
`define PIM_ADDR_PORT1_OUTPUT_MODE  8'hA5
`define PIM_ADDR_PORT2_OUTPUT_MODE  8'hA6
`define PIM_ADDR_PORT4_OUTPUT_MODE  8'hAE
`define PIM_ADDR_PORT3_OUTPUT_MODE  8'hAF
`define PIM_ADDR_PORT3_LATCH        8'hB0
`define PIM_ADDR_PORT2_MATCH_VALUE  8'hB1
`define PIM_ADDR_PORT2_MATCH_MASK   8'hB2
`define PIM_ADDR_PORT4_LATCH        8'hB5
`define PIM_ADDR_PORT1_SKIP         8'hD5
`define PIM_ADDR_PORT2_SKIP         8'hD6
`define PIM_ADDR_PORT3_SKIP         8'hD7
`define PIM_ADDR_PORT1_MATCH_VALUE  8'hE1
`define PIM_ADDR_PORT1_MATCH_MASK   8'hE2
`define PIM_ADDR_PORT1_INPUT_MODE   8'hF2
`define PIM_ADDR_PORT2_INPUT_MODE   8'hF3
`define PIM_ADDR_PORT3_INPUT_MODE   8'hF4

`define PIM_RST_ONES                8'hFF
`define PIM_RST_ZERO                8'h00
`define PIM_RST_PORT4_LATCH         8'h7F
`define PIM_PORT4_MASK              8'h7F

`endif

/* File: src/pim_pkg.sv */
// Types shared by the port configuration and match block
package pim_pkg;
  typedef logic [7:0] pim_byte_t;

  typedef struct packed {
    pim_byte_t p2_latch;
    pim_byte_t p3_latch;
    pim_byte_t p4_latch;
    pim_byte_t p1_omode;
    pim_byte_t p2_omode;
    pim_byte_t p3_omode;
    pim_byte_t p4_omode;
    pim_byte_t p1_imode;
    pim_byte_t p2_imode;
    pim_byte_t p3_imode;
    pim_byte_t p1_skip;
    pim_byte_t p2_skip;
    pim_byte_t p3_skip;
    pim_byte_t p1_mval;
    pim_byte_t p1_mmask;
    pim_byte_t p2_mval;
    pim_byte_t p2_mmask;
    pim_byte_t rd_data;
    pim_byte_t p2_oe;
    pim_byte_t p2_out;
    pim_byte_t p3_oe;
    pim_byte_t p3_out;
    pim_byte_t p4_oe;
    pim_byte_t p4_out;
    pim_byte_t p1_digital;
    pim_byte_t p2_digital;
    pim_byte_t p3_digital;
    pim_byte_t p1_skip_o;
    pim_byte_t p2_skip_o;
    pim_byte_t p3_skip_o;
    pim_byte_t p1_pushpull;
    logic      match_irq;
    logic      match_wake;
  } pim_state_s;
endpackage

/* File: src/pim_sync.sv */
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module pim_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pim_sync_s;

  pim_sync_s r;
  pim_sync_s next_r;

  // First stage feeds only the second stage
  always_comb begin
    next_r.stage1 = async_i;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_o = r.stage2;
endmodule // pim_sync

/* File: src/pim_pin_drive.sv */
// Per-pin output driver selection for one 8-bit port
`timescale 1ns/1ps
module pim_pin_drive (
  input  wire logic [7:0] latch_i,
  input  wire logic [7:0] push_pull_i,
  input  wire logic [7:0] digital_i,
  input  wire logic [7:0] xbar_sel_i,
  input  wire logic [7:0] xbar_out_i,
  input  wire logic [7:0] xbar_oe_i,
  output logic      [7:0] pin_out_o,
  output logic      [7:0] pin_oe_o
);
  logic [7:0] data;
  logic [7:0] pp;

  always_comb begin
    // Crossbar-owned pins take the peripheral value, others the latch
    data = (xbar_sel_i & xbar_out_i) | (~xbar_sel_i & latch_i);
    pp   = push_pull_i & digital_i;
    // Low drives on digital pins; high drives only in push-pull, else floats
    pin_out_o = data & digital_i;
    // Ownership is per pin, so the crossbar enable only counts where that pin is selected
    pin_oe_o  = digital_i & xbar_sel_i & xbar_oe_i & (~data | pp) |
                digital_i & ~xbar_sel_i & (~data | pp);
  end
endmodule // pim_pin_drive

/* File: tb/pim_port_io_monitor.sv */
// Concurrent checks on the port configuration and match block
`timescale 1ns/1ps
module pim_port_io_monitor (
  input wire logic       core_clk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic       sfr_rmw_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       match_interrupt_enable_i,
  input wire logic       match_irq_o,
  input wire logic       match_wake_o,
  input wire logic [7:0] port1_skip_o,
  input wire logic [7:0] port2_skip_o,
  input wire logic [7:0] port1_digital_o,
  input wire logic [7:0] port2_digital_o,
  input wire logic [7:0] port3_digital_o,
  input wire logic [7:0] port1_push_pull_o,
  input wire logic [7:0] port2_pin_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // --------
  // Checks
  // --------
  rd_idle_a: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
    else $error("read data not zero without a read");
  irq_gate_a: assert property (match_irq_o == (match_wake_o && $past(match_interrupt_enable_i)))
    else $error("interrupt request not gated wake");
  // Mode bits may settle one edge apart, so both samples of digital must be analog
  analog_oe_a: assert property ((port2_pin_oe_o & ~port2_digital_o & ~$past(port2_digital_o)) == 8'h00)
    else $error("analog pin driven");
  // Register lands on the write edge, its copy to the crossbar one edge later
  skip_write_a: assert property (sfr_wr_i && sfr_addr_i == 8'hD5 |-> ##2 port1_skip_o == $past(sfr_wdata_i, 2))
    else $error("skip output missed a write");
  skip_read_a: assert property (sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'hD6
    |=> sfr_rdata_o == $past(port2_skip_o))
    else $error("skip readback differs from skip output");
  p4_bit7_a: assert property (sfr_rd_i && (sfr_addr_i == 8'hB5 || sfr_addr_i == 8'hAE) |=> !sfr_rdata_o[7])
    else $error("unused port 4 bit read as one");
  analog_read_a: assert property (sfr_rd_i && !sfr_rmw_i && sfr_addr_i == 8'hA0
    |=> (sfr_rdata_o & ~$past(port2_digital_o)) == 8'h00)
    else $error("analog pin read as one");
  pp_digital_a: assert property ((port1_push_pull_o & ~port1_digital_o & ~$past(port1_digital_o)) == 8'h00)
    else $error("push-pull on analog pin");
  imode_read_a: assert property (sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'hF4
    |=> sfr_rdata_o == $past(port3_digital_o))
    else $error("input mode readback differs from digital output");
endmodule // pim_port_io_monitor

bind pim_port_io pim_port_io_monitor mon_u (.core_clk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
  .sfr_rmw_i, .sfr_wdata_i, .sfr_rdata_o, .match_interrupt_enable_i, .match_irq_o, .match_wake_o,
  .port1_skip_o, .port2_skip_o, .port1_digital_o, .port2_digital_o, .port3_digital_o,
  .port1_push_pull_o, .port2_pin_oe_o);

/* File: tb/pim_pin_model.sv */
// Pad model for one port: driver against what the board puts on the pin
`timescale 1ns/1ps
module pim_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] drv_oe_i,
  input  wire logic [W-1:0] drv_val_i,
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] pin_o
);
  // Undriven bits follow the board, never the last driven value
  assign pin_o = (drv_oe_i & drv_val_i) | (~drv_oe_i & ext_i);
endmodule // pim_pin_model

/* File: tb/pim_port_io_bench.sv */
// Self-checking bench for the port configuration and match block
`timescale 1ns/1ps
module pim_port_io_bench;
  logic       core_clk_i = 1'b0, reset_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, sfr_rmw_i = 1'b0;
  logic       sfr_bit_i = 1'b0, match_interrupt_enable_i = 1'b0, match_irq_o, match_wake_o;
  logic [2:0] sfr_bit_sel_i = 3'h0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, xsel = 8'h00, xout = 8'h00, xoe = 8'h00;
  logic [7:0] port1_skip_o, port2_skip_o, port3_skip_o, port1_digital_o, port2_digital_o, port3_digital_o;
  logic [7:0] port1_push_pull_o, port2_pin_o, port2_pin_oe_o, port3_pin_o, port3_pin_oe_o;
  logic [7:0] port1_pin_i = 8'hFF, port2_pin_i, port3_pin_i, ext2 = 8'hFF, ext3 = 8'hFF;
  logic [6:0] port4_pin_i, port4_pin_o, port4_pin_oe_o, ext4 = 7'h7F;
  int         n_errors = 0, check_count = 0, cyc = 0;
  localparam logic [7:0] RA [17] = '{8'hA0, 8'hA5, 8'hA6, 8'hAE, 8'hAF, 8'hB0, 8'hB1, 8'hB2, 8'hB5,
                                     8'hD5, 8'hD6, 8'hD7, 8'hE1, 8'hE2, 8'hF2, 8'hF3, 8'hF4};
  localparam logic [7:0] RV [17] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h7F,
                                     8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF};
  pim_port_io dut_u (.core_clk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_rmw_i, .sfr_bit_i,
    .sfr_bit_sel_i, .sfr_wdata_i, .sfr_rdata_o, .match_interrupt_enable_i, .match_irq_o, .match_wake_o,
    .xbar_p2_sel_i(xsel), .xbar_p2_out_i(xout), .xbar_p2_oe_i(xoe), .xbar_p3_sel_i(xsel),
    .xbar_p3_out_i(xout), .xbar_p3_oe_i(xoe), .xbar_p4_sel_i(xsel), .xbar_p4_out_i(xout),
    .xbar_p4_oe_i(xoe), .port1_skip_o, .port2_skip_o, .port3_skip_o, .port1_digital_o, .port2_digital_o,
    .port3_digital_o, .port1_push_pull_o, .port1_pin_i, .port2_pin_i, .port3_pin_i, .port4_pin_i,
    .port2_pin_o, .port2_pin_oe_o, .port3_pin_o, .port3_pin_oe_o, .port4_pin_o, .port4_pin_oe_o);
  pim_pin_model #(.W(8)) pad2_u (.drv_oe_i(port2_pin_oe_o), .drv_val_i(port2_pin_o), .ext_i(ext2),
    .pin_o(port2_pin_i));
  pim_pin_model #(.W(8)) pad3_u (.drv_oe_i(port3_pin_oe_o), .drv_val_i(port3_pin_o), .ext_i(ext3),
    .pin_o(port3_pin_i));
  pim_pin_model #(.W(7)) pad4_u (.drv_oe_i(port4_pin_oe_o), .drv_val_i(port4_pin_o), .ext_i(ext4),
    .pin_o(port4_pin_i));
  always #5 core_clk_i = ~core_clk_i;
  // ----------
  // Bus tasks
  // ----------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge core_clk_i);
    sfr_wr_i = 1'b0;
    sfr_bit_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
    @(negedge core_clk_i);
    sfr_addr_i = a;
    sfr_rmw_i = m;
    sfr_rd_i = 1'b1;
    @(negedge core_clk_i);
    sfr_rd_i = 1'b0;
    sfr_rmw_i = 1'b0;
    d = sfr_rdata_o;
  endtask
  // Covers both the two-edge drive path and the two-flop pin synchroniser
  task automatic settle;
    repeat (4) @(negedge core_clk_i);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    logic [7:0] d;
    for (int i = 0; i < 17; i++) begin
      rd(RA[i], 1'b1, d);
      chk("reset value", d, RV[i]);
    end
    chk("skip out", port1_skip_o | port2_skip_o | port3_skip_o, 8'h00);
    chk("digital out", port1_digital_o & port2_digital_o & port3_digital_o, 8'hFF);
    $display("test reset done");
  endtask
  task automatic t_rw;
    logic [7:0] d;
    for (int i = 0; i < 17; i++) wr(RA[i], 8'hA5);
    wr(8'hC0, 8'hA5);
    for (int i = 0; i < 17; i++) begin
      rd(RA[i], 1'b1, d);
      chk("readback", d, (RA[i] == 8'hAE || RA[i] == 8'hB5) ? 8'h25 : 8'hA5);
    end
    rd(8'hC0, 1'b0, d);
    chk("unmapped read", d, 8'h00);
    chk("skip copy", port1_skip_o & port3_skip_o, 8'hA5);
    chk("push-pull", port1_push_pull_o & port1_digital_o, 8'hA5);
    for (int i = 0; i < 17; i++) wr(RA[i], RV[i]);
    $display("test register access done");
  endtask
  task automatic t_drive;
    logic [7:0] d;
    wr(8'hA0, 8'h00);
    settle();
    chk("drive low", port2_pin_oe_o & ~port2_pin_o, 8'hFF);
    wr(8'hA0, 8'hFF);
    settle();
    chk("open-drain high", port2_pin_oe_o, 8'h00);
    wr(8'hA6, 8'hFF);
    settle();
    chk("push-pull high", port2_pin_oe_o & port2_pin_o, 8'hFF);
    wr(8'hF3, 8'hFE);
    wr(8'hD6, 8'h01);
    xsel = 8'h02;
    xoe = 8'h02;
    ext2 = 8'h5B;
    settle();
    chk("analog off", port2_pin_oe_o, 8'hFE);
    chk("crossbar owns", port2_pin_o, 8'hFC);
    chk("skip 2 out", port2_skip_o, 8'h01);
    rd(8'hA0, 1'b0, d);
    chk("pin read", d, 8'hFC);
    rd(8'hA0, 1'b1, d);
    chk("latch read", d, 8'hFF);
    xsel = 8'h00;
    xoe = 8'h00;
    wr(8'hF3, 8'hFF);
    wr(8'hD6, 8'h00);
    wr(8'hA6, 8'h00);
    $display("test port 2 drive done");
  endtask
  task automatic t_port34;
    logic [7:0] d;
    ext3 = 8'h3C;
    ext4 = 7'h55;
    wr(8'hF4, 8'h0F);
    wr(8'hD7, 8'hF0);
    settle();
    chk("port 3 float", port3_pin_oe_o, 8'h00);
    chk("port 3 analog low", port3_pin_o, 8'h0F);
    rd(8'hB0, 1'b0, d);
    chk("port 3 read", d, 8'h0C);
    rd(8'hB5, 1'b0, d);
    chk("port 4 read", d, 8'h55);
    wr(8'hAE, 8'hFF);
    settle();
    chk("port 4 drive", {1'b0, port4_pin_oe_o & port4_pin_o}, 8'h7F);
    sfr_bit_i = 1'b1;
    sfr_bit_sel_i = 3'h5;
    wr(8'hB0, 8'h00);
    rd(8'hB0, 1'b1, d);
    chk("bit write", d, 8'hDF);
    sfr_bit_i = 1'b1;
    wr(8'hB5, 8'h01);
    rd(8'hB5, 1'b1, d);
    chk("port 4 byte only", d, 8'h01);
    for (int i = 0; i < 17; i++) wr(RA[i], RV[i]);
    $display("test ports 3 and 4 done");
  endtask
  task automatic t_match;
    wr(8'hE2, 8'h0F);
    wr(8'hE1, 8'h05);
    port1_pin_i = 8'hF5;
    settle();
    chk("masked bits", {7'h00, match_wake_o}, 8'h00);
    port1_pin_i = 8'hF4;
    settle();
    chk("port 1 event", {6'h00, match_wake_o, match_irq_o}, 8'h02);
    match_interrupt_enable_i = 1'b1;
    settle();
    chk("irq enabled", {7'h00, match_irq_o}, 8'h01);
    port1_pin_i = 8'hF5;
    settle();
    chk("event clears", {7'h00, match_wake_o}, 8'h00);
    wr(8'hB2, 8'h80);
    wr(8'hB1, 8'h00);
    ext2 = 8'hDB;
    settle();
    chk("port 2 event", {7'h00, match_wake_o}, 8'h01);
    match_interrupt_enable_i = 1'b0;
    $display("test match done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    settle();
    t_reset();
    t_rw();
    t_drive();
    t_port34();
    t_match();
    summarize();
  end
endmodule // pim_port_io_bench
